// >>> hw/edac_cfg.svh
// Constants for the edge, delay and conversion event chain.
// Assumes a single 100 MHz clock and option bytes stable at reset release.
`ifndef EDAC_CFG_SVH
`define EDAC_CFG_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define EDAC_CLK_MHZ 100
`define EDAC_DELAY_US 2000
`define EDAC_DELAY_CYCLES (`EDAC_DELAY_US * `EDAC_CLK_MHZ)
`define EDAC_CNT_W 18
`define EDAC_CONV_CYCLES 16
`define EDAC_CONV_W 5

// ---------------------------------------------------------------
// Converter
// ---------------------------------------------------------------
`define EDAC_RES_W 10
`define EDAC_CH_W 3
`define EDAC_CH_SEL 3'h0

// ---------------------------------------------------------------
// Option byte codes
// ---------------------------------------------------------------
`define EDAC_OPT_WDT_STOP 8'hef
`define EDAC_OPT_HS64 8'hf8
`define EDAC_OPT_DEBUG 8'h84

`endif

// >>> hw/edac_pkg.sv
// Types for the edge, delay and conversion event chain.
// Assumes edac_cfg.svh is on the include path.
`default_nettype none
`include "edac_cfg.svh"

package edac_pkg;

   // ---------------------------------------------------------------
   // Chain states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      EDAC_IDLE = 3'b001,
      EDAC_DELAY = 3'b010,
      EDAC_CONV = 3'b100
   } edac_state_type;

   // ---------------------------------------------------------------
   // Option byte decode
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wdt_stop;
      logic hs64;
      logic dbg;
   } edac_opt_type;

   // ---------------------------------------------------------------
   // Whole module state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic edge_s1;
      logic edge_s2;
      logic edge_prev;
      logic [`EDAC_RES_W-1:0] ana_s1;
      logic [`EDAC_RES_W-1:0] ana_s2;
      edac_state_type st;
      logic pend;
      logic [`EDAC_CNT_W-1:0] cnt;
      logic [`EDAC_CONV_W-1:0] conv_cnt;
      logic [`EDAC_RES_W-1:0] sample;
      logic done;
      logic start;
      logic irq;
      logic [`EDAC_RES_W-1:0] result;
      logic opt_taken;
      edac_opt_type opt;
   } edac_state_rec_type;

endpackage : edac_pkg
`default_nettype wire

// >>> hw/edac_chain.sv
// Edge to delay to conversion event chain, all in hardware.
// Assumes pin inputs are asynchronous and option bytes are static straps.
`default_nettype none
`include "edac_cfg.svh"

module edac_chain
   import edac_pkg::*;
#(
   parameter int P_DELAY_CYCLES = `EDAC_DELAY_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ext_edge_input0,
   input wire logic [`EDAC_RES_W-1:0] i_analog_input0,
   input wire logic i_edge_link_en,
   input wire logic i_adc_link_en,
   input wire logic [7:0] i_opt_byte0,
   input wire logic [7:0] i_opt_byte2,
   input wire logic [7:0] i_opt_byte3,
   output logic o_delay_done_event,
   output logic o_adc_start,
   output logic [`EDAC_CH_W-1:0] o_adc_channel,
   output logic o_adc_end_irq,
   output logic [`EDAC_RES_W-1:0] o_adc_result,
   output logic o_busy,
   output logic o_wdt_stopped,
   output logic o_fast_internal_osc_64m,
   output logic o_debug_en
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   edac_state_rec_type r_q;
   edac_state_rec_type r_d;
   logic edge_evt;

   default clocking cb_edac @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   localparam logic [`EDAC_CNT_W-1:0] L_DELAY_LAST =
      `EDAC_CNT_W'(P_DELAY_CYCLES - 1);
   localparam logic [`EDAC_CONV_W-1:0] L_CONV_LAST =
      `EDAC_CONV_W'(`EDAC_CONV_CYCLES - 1);

   function automatic logic opt_match(input logic [7:0] val,
                                      input logic [7:0] code);
      opt_match = (val == code);
   endfunction : opt_match

   assign edge_evt = r_q.edge_s2 & ~r_q.edge_prev & i_edge_link_en;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      r_d.edge_s1 = i_ext_edge_input0;
      r_d.edge_s2 = r_q.edge_s1;
      r_d.edge_prev = r_q.edge_s2;
      r_d.ana_s1 = i_analog_input0;
      r_d.ana_s2 = r_q.ana_s1;
      r_d.done = 1'b0;
      r_d.start = 1'b0;
      r_d.irq = 1'b0;
      // Option bytes taken once after reset release
      if (!r_q.opt_taken) begin
         r_d.opt_taken = 1'b1;
         r_d.opt.wdt_stop = opt_match(i_opt_byte0, `EDAC_OPT_WDT_STOP);
         r_d.opt.hs64 = opt_match(i_opt_byte2, `EDAC_OPT_HS64);
         r_d.opt.dbg = opt_match(i_opt_byte3, `EDAC_OPT_DEBUG);
      end
      // Event chain, no software step anywhere
      unique case (r_q.st)
         EDAC_IDLE: begin
            if (edge_evt) begin
               r_d.st = EDAC_DELAY;
               r_d.cnt = '0;
            end
         end
         EDAC_DELAY: begin
            if (edge_evt) begin
               r_d.cnt = '0;
            end else if (r_q.cnt == L_DELAY_LAST) begin
               r_d.done = 1'b1;
               r_d.cnt = '0;
               if (i_adc_link_en) begin
                  r_d.st = EDAC_CONV;
                  r_d.start = 1'b1;
                  r_d.conv_cnt = '0;
                  r_d.sample = r_q.ana_s2;
               end else begin
                  r_d.st = EDAC_IDLE;
               end
            end else begin
               r_d.cnt = r_q.cnt + `EDAC_CNT_W'(1);
            end
         end
         EDAC_CONV: begin
            if (edge_evt) begin
               r_d.pend = 1'b1;
            end
            if (r_q.conv_cnt == L_CONV_LAST) begin
               r_d.irq = 1'b1;
               r_d.result = r_q.sample;
               r_d.pend = 1'b0;
               r_d.cnt = '0;
               r_d.st = (r_q.pend | edge_evt) ? EDAC_DELAY : EDAC_IDLE;
            end else begin
               r_d.conv_cnt = r_q.conv_cnt + `EDAC_CONV_W'(1);
            end
         end
         default: begin
            r_d.st = EDAC_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         r_q <= '0;
         r_q.st <= EDAC_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign o_delay_done_event = r_q.done;
   assign o_adc_start = r_q.start;
   assign o_adc_channel = `EDAC_CH_SEL;
   assign o_adc_end_irq = r_q.irq;
   assign o_adc_result = r_q.result;
   assign o_busy = ~r_q.st[0];
   assign o_wdt_stopped = r_q.opt.wdt_stop;
   assign o_fast_internal_osc_64m = r_q.opt.hs64;
   assign o_debug_en = r_q.opt.dbg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   localparam int L_CONV_N = `EDAC_CONV_CYCLES;
   localparam int L_PEND_MAX = `EDAC_CONV_CYCLES - 1;

   sequence seq_edge_idle;
      edge_evt && r_q.st == EDAC_IDLE;
   endsequence

   sequence seq_delay_end;
      r_q.st == EDAC_DELAY && !edge_evt && r_q.cnt == L_DELAY_LAST &&
         i_adc_link_en;
   endsequence

   sequence seq_pend_conv;
      r_q.st == EDAC_CONV && r_q.pend;
   endsequence

   AST_EDGE_START: assert property (
      seq_edge_idle |=> r_q.st == EDAC_DELAY && r_q.cnt == '0)
      else $error("Edge did not start the delay count");

   AST_DONE_CAUSE: assert property (
      o_delay_done_event |-> $past(r_q.st) == EDAC_DELAY &&
         $past(r_q.cnt) == L_DELAY_LAST)
      else $error("Delay done without terminal count");

   AST_DONE_PULSE: assert property (
      o_delay_done_event |=> !o_delay_done_event)
      else $error("Delay done longer than one cycle");

   AST_START_LINK: assert property (
      seq_delay_end |=> o_adc_start && o_delay_done_event &&
         r_q.st == EDAC_CONV)
      else $error("Delay end did not start a conversion");

   AST_CHANNEL: assert property (
      o_adc_start |-> o_adc_channel == `EDAC_CH_SEL &&
         r_q.sample == $past(r_q.ana_s2))
      else $error("Conversion did not sample channel 0");

   AST_CONV_END: assert property (
      o_adc_start |-> ##[L_CONV_N:L_CONV_N] (o_adc_end_irq &&
         o_adc_result == $past(r_q.sample)))
      else $error("Conversion end request missing or late");

   AST_IRQ_PULSE: assert property (
      o_adc_end_irq |=> !o_adc_end_irq)
      else $error("Conversion end request longer than one cycle");

   // A remembered edge must rerun the delay when the conversion ends
   AST_RERUN: assert property (
      seq_pend_conv |-> ##[1:L_PEND_MAX] (o_adc_end_irq &&
         r_q.st == EDAC_DELAY && r_q.cnt == '0))
      else $error("Pending edge lost");

   AST_PEND_DELAY: assert property (
      (o_adc_end_irq && $past(r_q.pend)) |-> r_q.st == EDAC_DELAY &&
         r_q.cnt == '0)
      else $error("Pending edge did not rerun the delay");

   AST_OPT: assert property (
      $rose(r_q.opt_taken) |-> o_wdt_stopped ==
         ($past(i_opt_byte0) == `EDAC_OPT_WDT_STOP))
      else $error("Watchdog stop option misdecoded");

   AST_OSC: assert property (
      $rose(r_q.opt_taken) |-> o_fast_internal_osc_64m ==
         ($past(i_opt_byte2) == `EDAC_OPT_HS64))
      else $error("Oscillator option misdecoded");

   AST_DBG: assert property (
      $rose(r_q.opt_taken) |-> o_debug_en ==
         ($past(i_opt_byte3) == `EDAC_OPT_DEBUG) ##1 $stable(o_debug_en))
      else $error("Debug enable option misdecoded or changed");

endmodule : edac_chain
`default_nettype wire

// >>> testbench/edac_far_end.sv
// Far-side model: the edge source pin and the digitised channel-0 level.
// Assumes the bench calls its tasks just after a falling clock edge.
`default_nettype none
`include "edac_cfg.svh"
module edac_far_end (
   input wire logic i_clk,
   output logic o_edge,
   output logic [`EDAC_RES_W-1:0] o_level
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_edge = 1'b0;
      o_level = '0;
   end
   // Level held steady until the conversion has sampled it
   task automatic set_level(input logic [`EDAC_RES_W-1:0] v);
      o_level = v;
   endtask : set_level
   // Rising edge, held high for some clocks, then low again
   task automatic pulse(input int hold);
      o_edge = 1'b1;
      repeat (hold) @(negedge i_clk);
      o_edge = 1'b0;
   endtask : pulse
endmodule : edac_far_end
`default_nettype wire

// >>> testbench/edge_delay_adc_event_chain_tb_top.sv
// Bench for the edge, delay and conversion chain, short delay count.
// Assumes edac_pkg, edac_chain and edac_far_end are compiled first.
`default_nettype none
`include "edac_cfg.svh"
module edge_delay_adc_event_chain_tb_top
   import edac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int P = 20;
   localparam int LIMIT = 3000;
   typedef struct packed {
      logic ee;
      logic ae;
      logic [`EDAC_RES_W-1:0] lvl;
      logic [1:0] nd;
      logic [1:0] ni;
   } edac_tb_row_type;
   edac_tb_row_type rows [5] = '{
      '{1'b1, 1'b1, 10'h3ff, 2'h1, 2'h1}, '{1'b1, 1'b1, 10'h000, 2'h1, 2'h1},
      '{1'b1, 1'b1, 10'h155, 2'h1, 2'h1}, '{1'b1, 1'b0, 10'h2aa, 2'h1, 2'h0},
      '{1'b0, 1'b1, 10'h123, 2'h0, 2'h0}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en_e = 1'b0;
   logic en_a = 1'b0;
   logic [7:0] ob0 = 8'h00, ob2 = 8'h00, ob3 = 8'h00;
   logic pin, done, start, irq, busy, wdt, osc, dbg;
   logic [`EDAC_RES_W-1:0] lvl, res_o, res;
   logic [`EDAC_CH_W-1:0] ch;
   int n_errors = 0, compares = 0, cyc = 0, s = 0;
   int n_done = 0, n_start = 0, n_irq = 0, t_done = 0, t_irq = 0;

   edac_far_end edac_far_end_i (.i_clk(clk), .o_edge(pin), .o_level(lvl));
   edac_chain #(.P_DELAY_CYCLES(P)) edac_chain_i (
      .i_clk(clk), .i_reset(rst), .i_ext_edge_input0(pin),
      .i_analog_input0(lvl), .i_edge_link_en(en_e), .i_adc_link_en(en_a),
      .i_opt_byte0(ob0), .i_opt_byte2(ob2), .i_opt_byte3(ob3),
      .o_delay_done_event(done), .o_adc_start(start), .o_adc_channel(ch),
      .o_adc_end_irq(irq), .o_adc_result(res_o), .o_busy(busy),
      .o_wdt_stopped(wdt), .o_fast_internal_osc_64m(osc), .o_debug_en(dbg));

   // ----
   // Checking tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   function automatic logic lat_ok(input int d);
      return d >= P + 3 && d <= P + 6;
   endfunction : lat_ok
   task automatic clr();
      n_done = 0;
      n_start = 0;
      n_irq = 0;
   endtask : clr
   task automatic do_reset(input logic [7:0] a, b, c);
      ob0 = a;
      ob2 = b;
      ob3 = c;
      rst = 1'b1;
      repeat (3) @(negedge clk);
      chk({busy, irq, wdt, osc, dbg, ch}, '0);
      rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask : do_reset
   task automatic run_row(input edac_tb_row_type r);
      en_e = r.ee;
      en_a = r.ae;
      edac_far_end_i.set_level(r.lvl);
      clr();
      repeat (4) @(negedge clk);
      s = cyc;
      edac_far_end_i.pulse(2);
      repeat (4) @(negedge clk);
      chk(busy, r.ee);
      repeat (P + 36) @(negedge clk);
      chk(n_done, r.nd);
      chk(n_start, r.ni);
      chk(n_irq, r.ni);
      chk(busy, 1'b0);
      if (r.ni != 0) begin
         chk(res, r.lvl);
         chk(t_irq - t_done, 16);
      end
      if (r.nd != 0) begin
         chk(lat_ok(t_done - s), 1'b1);
      end
   endtask : run_row

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Output monitor, a moment after each rising edge
   always @(posedge clk) begin
      #1;
      cyc++;
      if (done === 1'b1) begin
         n_done++;
         t_done = cyc;
      end
      if (start === 1'b1) begin
         n_start++;
         chk(done, 1'b1);
         chk(ch, 3'h0);
      end
      if (irq === 1'b1) begin
         n_irq++;
         t_irq = cyc;
         res = res_o;
      end
      if (cyc == LIMIT) begin
         n_errors++;
         give_verdict();
      end
   end

   // ----
   // Main sequence
   // ----
   initial begin
      do_reset(8'hef, 8'hf8, 8'h84);
      chk({wdt, osc, dbg}, 3'b111);
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      en_e = 1'b1;
      en_a = 1'b1;
      // Second edge in mid-delay restarts the count
      clr();
      edac_far_end_i.pulse(2);
      repeat (P / 2) @(negedge clk);
      s = cyc;
      edac_far_end_i.pulse(2);
      repeat (P + 40) @(negedge clk);
      chk(n_done, 1);
      chk(lat_ok(t_done - s), 1'b1);
      // Edge during conversion reruns the chain afterwards
      clr();
      edac_far_end_i.pulse(2);
      repeat (P + 8) @(negedge clk);
      edac_far_end_i.pulse(2);
      repeat (2 * P + 60) @(negedge clk);
      chk(n_irq, 2);
      chk(n_start, 2);
      do_reset(8'hee, 8'hf9, 8'h04);
      chk({wdt, osc, dbg}, 3'b000);
      give_verdict();
   end
endmodule : edge_delay_adc_event_chain_tb_top
`default_nettype wire
